// [include/rgc_pkg.sv]
package rgc_pkg;
    // wishbone word byte offsets
    localparam logic [7:0] ADDR_FRONT_AMP = 8'h00;
    localparam logic [7:0] ADDR_LIMIT = 8'h04;
    localparam logic [7:0] ADDR_RX_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STEP_LIM_LO = 8'h0C;
    localparam logic [7:0] ADDR_STEP_LIM_HI = 8'h10;
    localparam logic [7:0] ADDR_DGAIN_CFG = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_BW = 8'h1C;
    // front_amp_config fields
    localparam int LNA_ZIN_BIT = 7;
    localparam int LNA_NOW_LSB = 3;
    localparam int LNA_CODE_LSB = 0;
    localparam logic [2:0] GAIN_AUTO = 3'h0;
    localparam logic [2:0] GAIN_G1 = 3'h1;
    localparam logic [2:0] GAIN_G6 = 3'h6;
    // rx control fields
    localparam int RX_EN_BIT = 0;
    localparam int PKT_MODE_BIT = 1;
    localparam int AUTO_REARM_BIT = 2;
    localparam int REARM_CMD_BIT = 3;
    localparam int AFC_EN_BIT = 4;
    localparam int DELAY_LSB = 8;
    // resets
    localparam logic [7:0] FRONT_AMP_RST = 8'h08;
    localparam logic [7:0] LIMIT_RST = 8'hE4;
    localparam logic [15:0] RX_CTRL_RST = 16'h0002;
    localparam logic [7:0] DGAIN_RST = 8'h30;
    localparam logic [7:0] DGAIN_LOWBETA = 8'h20;
    localparam logic [7:0] DGAIN_OFF = 8'h00;
    localparam logic [15:0] BW_RST = 16'h5555;
    localparam logic [31:0] STEP_LIM_LO_RST = 32'hC0A08060;
    localparam logic [7:0] STEP_LIM_HI_RST = 8'hE0;
    localparam logic [7:0] DGAIN_INIT = 8'h80;
    // reference level terms in dB
    localparam int REF_FLOOR_DB = -174;
    localparam int NOISE_FIG_DB = 7;
    localparam int DEMOD_SNR_TERM_DB = 8;
    localparam int FADE_MARGIN_TERM_DB = 5;
    localparam int QUALIFY_COUNT = 2;
    localparam int DGAIN_PERIOD_BITS = 2;
    // bit period in clocks at 125 MHz, parameter default
    localparam int BIT_CLKS_DEF = 16;
    localparam logic [7:0] REARM_UNIT_BITS = 8'h08;
endpackage

// [verilog/rgc_top.sv]
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RULE1] code 000 gives lna gain to the automatic loop
// [RULE2] codes 001..110 force fixed gains max down to max-48 dB
// [RULE3] host never programs reserved code 111
// [RULE4] one bit picks 50 or 200 ohm lna input impedance
// [RULE5] auto mode waits until level exceeds limit two samples running
// [RULE6] leaving wait picks gain step fitting measured input level
// [RULE7] chosen gain held for packet and readable as current gain
// [RULE8] packet mode without auto rearm keeps gain for next packet
// [RULE9] auto rearm waits rearm delay after fifo empty, then wait state
// [RULE10] rearm command always returns to wait state; the code acts on it only while rx_en is set, else the state stays ST_IDLE
// [RULE11] in continuous mode host keeps gain or issues rearm
// [RULE12] host acquires gain during preamble, or constant ones for ook
// [RULE13] host sets level limit to receiver sensitivity
// [RULE14] during afc and acquisition the afc bandwidth is used
// [RULE15] reference level is -174+nf+snr+10log(2bw)+fade margin
// [RULE16] five ascending limits map power to six gain steps
// [RULE17] digital gain stage updates every two bit periods
// [RULE18] digital gain keeps adjusting while lna gain frozen
// [RULE19] digital gain acts alike in all data modes
// [RULE20] host enables digital gain with 0x20 low index, else 0x30
// [RULE21] digital gain always enabled is recommended
// [RULE22] one failing sample clears the qualifying count
module rgc_top #(
    parameter int BIT_CLKS = rgc_pkg::BIT_CLKS_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] signal_level_i,
    input wire logic level_valid_i,
    input wire logic fifo_empty_i,
    input wire logic afc_busy_i,
    input wire logic [7:0] digital_amp_i,
    output logic [2:0] lna_gain_o,
    output logic lna_impedance_sel_o,
    output logic [7:0] bandwidth_o,
    output logic [7:0] digital_gain_o,
    output logic digital_gain_tick_o,
    output logic in_wait_o,
    output logic signed [9:0] ref_level_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HOLD, ST_DELAY} rgc_state_t;
    rgc_state_t state_r, state_nxt;

    logic [7:0] front_amp_config_r;
    logic [7:0] signal_limit_reg_r;
    logic [15:0] rx_ctrl_r;
    logic [31:0] step_lim_lo_r;
    logic [7:0] step_lim_hi_r;
    logic [7:0] digital_gain_cfg_r;
    logic [15:0] bw_r;
    logic [2:0] lna_gain_now_r;
    logic [1:0] qual_cnt_r;
    logic [15:0] delay_cnt_r;
    logic [15:0] bit_cnt_r;
    logic bit_phase_r;
    logic [7:0] dgain_r;
    logic dgain_tick_r;
    logic [31:0] dat_r;
    logic ack_r;
    logic [2:0] lna_out_r;
    logic [7:0] bw_out_r;
    logic signed [9:0] ref_r;
    logic in_wait_r;

    wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    wire bus_wr = bus_req && wb_we_i;
    wire wr_amp = bus_wr && wb_adr_i == rgc_pkg::ADDR_FRONT_AMP && wb_sel_i[0];
    wire wr_lim = bus_wr && wb_adr_i == rgc_pkg::ADDR_LIMIT && wb_sel_i[0];
    wire wr_ctl = bus_wr && wb_adr_i == rgc_pkg::ADDR_RX_CTRL;
    wire wr_slo = bus_wr && wb_adr_i == rgc_pkg::ADDR_STEP_LIM_LO;
    wire wr_shi = bus_wr && wb_adr_i == rgc_pkg::ADDR_STEP_LIM_HI && wb_sel_i[0];
    wire wr_dg = bus_wr && wb_adr_i == rgc_pkg::ADDR_DGAIN_CFG && wb_sel_i[0];
    wire wr_bw = bus_wr && wb_adr_i == rgc_pkg::ADDR_BW;
    // command bit is self clearing, never stored
    wire rearm_cmd = wr_ctl && wb_sel_i[0] && wb_dat_i[rgc_pkg::REARM_CMD_BIT];
    wire rx_en = rx_ctrl_r[rgc_pkg::RX_EN_BIT];
    wire pkt_mode = rx_ctrl_r[rgc_pkg::PKT_MODE_BIT];
    wire auto_rx_rearm = rx_ctrl_r[rgc_pkg::AUTO_REARM_BIT];
    wire afc_en = rx_ctrl_r[rgc_pkg::AFC_EN_BIT];
    wire [7:0] rearm_delay = rx_ctrl_r[15:rgc_pkg::DELAY_LSB];
    wire [2:0] lna_gain_code = front_amp_config_r[2:0];
    // [RULE1] automatic mode select
    wire auto_mode = lna_gain_code == rgc_pkg::GAIN_AUTO;
    wire above = level_valid_i && signal_level_i > signal_limit_reg_r;
    wire qualified = above && qual_cnt_r == 2'(rgc_pkg::QUALIFY_COUNT - 1);
    wire dg_en = digital_gain_cfg_r != rgc_pkg::DGAIN_OFF;

    // [RULE16] step from five ascending limits
    function automatic logic [2:0] pick_step(input logic [7:0] lvl, input logic [39:0] lim);
        logic [2:0] s;
        s = rgc_pkg::GAIN_G1;
        for (int i = 0; i < 5; i++) begin
            if (lvl > lim[i*8 +: 8]) begin
                s = 3'(i + 2);
            end
        end
        return s;
    endfunction

    function automatic logic [7:0] byte_mux(input logic [7:0] old, input logic [7:0] nw,
                                            input logic en);
        return en ? nw : old;
    endfunction

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (rx_en) begin
                    state_nxt = ST_WAIT;
                end
            end
            // [RULE5] wait for two samples above limit
            ST_WAIT: begin
                if (qualified) begin
                    state_nxt = ST_HOLD;
                end
            end
            // [RULE8] no rearm keeps gain
            ST_HOLD: begin
                if (pkt_mode && auto_rx_rearm && fifo_empty_i) begin
                    state_nxt = ST_DELAY;
                end
            end
            // [RULE9] delay then rearm
            ST_DELAY: begin
                if (delay_cnt_r == 16'h0000) begin
                    state_nxt = ST_WAIT;
                end
            end
        endcase
        // [RULE10] rearm command wins
        if (rearm_cmd && rx_en) begin
            state_nxt = ST_WAIT;
        end
        if (!rx_en) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            qual_cnt_r <= 2'h0;
            delay_cnt_r <= 16'h0000;
            lna_gain_now_r <= rgc_pkg::GAIN_G1;
        end else begin
            state_r <= state_nxt;
            // [RULE22] failed sample clears count
            if (state_r != ST_WAIT || (level_valid_i && !above)) begin
                qual_cnt_r <= 2'h0;
            end else if (above && !qualified) begin
                qual_cnt_r <= qual_cnt_r + 2'h1;
            end
            if (state_r == ST_HOLD) begin
                delay_cnt_r <= 16'(rearm_delay * rgc_pkg::REARM_UNIT_BITS * BIT_CLKS);
            end else if (delay_cnt_r != 16'h0000) begin
                delay_cnt_r <= delay_cnt_r - 16'h0001;
            end
            // [RULE6] gain picked on wait exit
            if (!auto_mode) begin
                lna_gain_now_r <= lna_gain_code;
            end else if (state_r == ST_WAIT && qualified) begin
                lna_gain_now_r <= pick_step(signal_level_i, {step_lim_hi_r, step_lim_lo_r});
            end
        end
    end

    // [RULE17] two bit period tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_cnt_r <= 16'h0000;
            bit_phase_r <= 1'b0;
            dgain_tick_r <= 1'b0;
            dgain_r <= rgc_pkg::DGAIN_INIT;
        end else begin
            dgain_tick_r <= 1'b0;
            if (bit_cnt_r == 16'(BIT_CLKS - 1)) begin
                bit_cnt_r <= 16'h0000;
                bit_phase_r <= !bit_phase_r;
                // [RULE18] independent of lna hold and [RULE19] of data mode
                if (bit_phase_r && dg_en && rx_en) begin
                    dgain_tick_r <= 1'b1;
                    if (digital_amp_i < 8'h70 && dgain_r != 8'hFF) begin
                        dgain_r <= dgain_r + 8'h01;
                    end else if (digital_amp_i > 8'h90 && dgain_r != 8'h00) begin
                        dgain_r <= dgain_r - 8'h01;
                    end
                end
            end else begin
                bit_cnt_r <= bit_cnt_r + 16'h0001;
            end
        end
    end

    // register file
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            front_amp_config_r <= rgc_pkg::FRONT_AMP_RST;
            signal_limit_reg_r <= rgc_pkg::LIMIT_RST;
            rx_ctrl_r <= rgc_pkg::RX_CTRL_RST;
            step_lim_lo_r <= rgc_pkg::STEP_LIM_LO_RST;
            step_lim_hi_r <= rgc_pkg::STEP_LIM_HI_RST;
            digital_gain_cfg_r <= rgc_pkg::DGAIN_RST;
            bw_r <= rgc_pkg::BW_RST;
        end else begin
            // [RULE4] impedance bit, [RULE2] fixed code
            if (wr_amp) begin
                front_amp_config_r <= wb_dat_i[7:0];
            end
            if (wr_lim) begin
                signal_limit_reg_r <= wb_dat_i[7:0];
            end
            if (wr_ctl) begin
                rx_ctrl_r[7:0] <= byte_mux(rx_ctrl_r[7:0], wb_dat_i[7:0] & 8'hF7, wb_sel_i[0]);
                rx_ctrl_r[15:8] <= byte_mux(rx_ctrl_r[15:8], wb_dat_i[15:8], wb_sel_i[1]);
            end
            if (wr_slo) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) begin
                        step_lim_lo_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                    end
                end
            end
            if (wr_shi) begin
                step_lim_hi_r <= wb_dat_i[7:0];
            end
            if (wr_dg) begin
                digital_gain_cfg_r <= wb_dat_i[7:0];
            end
            if (wr_bw) begin
                bw_r[7:0] <= byte_mux(bw_r[7:0], wb_dat_i[7:0], wb_sel_i[0]);
                bw_r[15:8] <= byte_mux(bw_r[15:8], wb_dat_i[15:8], wb_sel_i[1]);
            end
        end
    end

    // [RULE7] current gain readback
    wire [7:0] amp_rd = {front_amp_config_r[rgc_pkg::LNA_ZIN_BIT], 1'b0, lna_gain_now_r,
                         lna_gain_code};
    wire [31:0] rd_mux =
        wb_adr_i == rgc_pkg::ADDR_FRONT_AMP ? {24'h0, amp_rd} :
        wb_adr_i == rgc_pkg::ADDR_LIMIT ? {24'h0, signal_limit_reg_r} :
        wb_adr_i == rgc_pkg::ADDR_RX_CTRL ? {16'h0, rx_ctrl_r} :
        wb_adr_i == rgc_pkg::ADDR_STEP_LIM_LO ? step_lim_lo_r :
        wb_adr_i == rgc_pkg::ADDR_STEP_LIM_HI ? {24'h0, step_lim_hi_r} :
        wb_adr_i == rgc_pkg::ADDR_DGAIN_CFG ? {24'h0, digital_gain_cfg_r} :
        wb_adr_i == rgc_pkg::ADDR_STATUS ? {16'h0, dgain_r, 4'h0, 2'(state_r), 2'h0} :
        wb_adr_i == rgc_pkg::ADDR_BW ? {16'h0, bw_r} : 32'h0;

    // [RULE14] afc bandwidth while correcting or acquiring
    wire use_afc_bw = afc_en && (afc_busy_i || state_r == ST_WAIT);
    // [RULE15] reference from bandwidth log term in the bw byte in use: high byte while afc bw is used, else low byte
    wire signed [9:0] ref_calc = 10'(rgc_pkg::REF_FLOOR_DB + rgc_pkg::NOISE_FIG_DB +
        rgc_pkg::DEMOD_SNR_TERM_DB + rgc_pkg::FADE_MARGIN_TERM_DB) +
        10'({2'h0, (use_afc_bw ? bw_r[15:8] : bw_r[7:0])});

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
            lna_out_r <= rgc_pkg::GAIN_G1;
            bw_out_r <= 8'h00;
            ref_r <= 10'sh000;
            in_wait_r <= 1'b0;
        end else begin
            // from next state so the flag lines up with state_r
            in_wait_r <= state_nxt == ST_WAIT;
            ack_r <= bus_req;
            dat_r <= bus_req ? rd_mux : 32'h0;
            lna_out_r <= lna_gain_now_r;
            bw_out_r <= use_afc_bw ? bw_r[15:8] : bw_r[7:0];
            ref_r <= ref_calc;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign lna_gain_o = lna_out_r;
    assign lna_impedance_sel_o = front_amp_config_r[rgc_pkg::LNA_ZIN_BIT];
    assign bandwidth_o = bw_out_r;
    assign digital_gain_o = dgain_r;
    assign digital_gain_tick_o = dgain_tick_r;
    assign in_wait_o = in_wait_r;
    assign ref_level_o = ref_r;

    a_wait_exit: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
        $rose(state_r == ST_HOLD) |-> $past(above) &&
        $past(qual_cnt_r) == 2'(rgc_pkg::QUALIFY_COUNT - 1))
        else $error("wait left without two samples");
    a_fixed_gain: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
        !auto_mode && $stable(lna_gain_code) |=> lna_gain_now_r == $past(lna_gain_code))
        else $error("fixed gain not applied");
    a_gain_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
        auto_mode && $past(auto_mode) && state_r == ST_HOLD && $past(state_r) == ST_HOLD
        |-> $stable(lna_gain_now_r))
        else $error("gain moved in hold");
    a_rearm_cmd: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
        rearm_cmd && rx_en |=> state_r == ST_WAIT)
        else $error("rearm ignored");
    a_no_auto: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
        state_r == ST_HOLD && !auto_rx_rearm && !rearm_cmd && rx_en |=> state_r == ST_HOLD)
        else $error("gain released without rearm");
    sequence s_rearm_start;
        state_r == ST_HOLD && pkt_mode && auto_rx_rearm && fifo_empty_i && rx_en;
    endsequence
    a_delay_go: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
        s_rearm_start |=> state_r == ST_DELAY || state_r == ST_WAIT)
        else $error("auto rearm not started");
    a_qual_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE22]
        level_valid_i && !above |=> qual_cnt_r == 2'h0)
        else $error("count kept after fail");
    a_tick_space: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE17]
        dgain_tick_r |=> !dgain_tick_r [*2])
        else $error("digital gain ticks too close");
    a_step_pick: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
        auto_mode && state_r == ST_WAIT && qualified |=> lna_gain_now_r != 3'h0 &&
        lna_gain_now_r <= rgc_pkg::GAIN_G6)
        else $error("illegal auto step");
endmodule
`default_nettype wire

// [test/rgc_front_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rgc_front_model (
    input wire logic clk_i,
    output logic [7:0] signal_level_o,
    output logic level_valid_o,
    output logic [7:0] digital_amp_o
);
    initial begin
        signal_level_o = 8'h00;
        level_valid_o = 1'b0;
        digital_amp_o = 8'h40;
    end
    // steady level per sample
    // one-cycle valid pulse; bus inverted after so stale data never looks valid
    task automatic sample(input logic [7:0] lvl);
        @(posedge clk_i);
        signal_level_o <= lvl;
        level_valid_o <= 1'b1;
        @(posedge clk_i);
        level_valid_o <= 1'b0;
        signal_level_o <= ~lvl;
    endtask
    task automatic set_amp(input logic [7:0] amp);
        @(posedge clk_i);
        digital_amp_o <= amp;
    endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int BITC = 4;
    logic clk_i = 1'b0;
    logic rst_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [3:0] wb_sel_i;
    logic fifo_empty_i;
    logic afc_busy_i;
    logic [3:0] wb_lanes;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [7:0] signal_level_i;
    logic level_valid_i;
    logic [7:0] digital_amp_i;
    logic [2:0] lna_gain_o;
    logic lna_impedance_sel_o;
    logic [7:0] bandwidth_o;
    logic [7:0] digital_gain_o;
    logic digital_gain_tick_o;
    logic in_wait_o;
    logic signed [9:0] ref_level_o;
    logic [31:0] rd;
    int n_errors = 0;
    int samples_checked = 0;
    int n;
    always #4 clk_i = ~clk_i;
    rgc_top #(.BIT_CLKS(BITC)) rgc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .signal_level_i(signal_level_i), .level_valid_i(level_valid_i),
        .fifo_empty_i(fifo_empty_i), .afc_busy_i(afc_busy_i), .digital_amp_i(digital_amp_i),
        .lna_gain_o(lna_gain_o), .lna_impedance_sel_o(lna_impedance_sel_o),
        .bandwidth_o(bandwidth_o), .digital_gain_o(digital_gain_o),
        .digital_gain_tick_o(digital_gain_tick_o), .in_wait_o(in_wait_o),
        .ref_level_o(ref_level_o));
    rgc_front_model rgc_front_model_i (.clk_i(clk_i), .signal_level_o(signal_level_i),
        .level_valid_o(level_valid_i), .digital_amp_o(digital_amp_i));
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // classic cycle: hold until ack seen at a rising edge, then release
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= wb_lanes;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 40);
        rd = wb_dat_o;
        if (k >= 40) chk(32'h1, 32'h0, "no ack");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask
    task automatic t_reset();
        wb(1'b0, rgc_pkg::ADDR_FRONT_AMP, 32'h0);
        chk(rd & 32'hBF, {24'h0, rgc_pkg::FRONT_AMP_RST}, "amp rst");
        wb(1'b0, rgc_pkg::ADDR_LIMIT, 32'h0);
        chk(rd & 32'hFF, {24'h0, rgc_pkg::LIMIT_RST}, "limit rst");
        wb(1'b0, rgc_pkg::ADDR_DGAIN_CFG, 32'h0);
        chk(rd & 32'hFF, {24'h0, rgc_pkg::DGAIN_RST}, "dgain rst");
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        wb(1'b1, 8'h40, 32'hFF);
        wb(1'b0, rgc_pkg::ADDR_LIMIT, 32'h0);
        chk(rd & 32'hFF, {24'h0, rgc_pkg::LIMIT_RST}, "unmapped write leak");
        // byte lane 0 off: an 8-bit register must not take the write
        wb_lanes = 4'hE;
        wb(1'b1, rgc_pkg::ADDR_LIMIT, 32'h11);
        wb_lanes = 4'hF;
        wb(1'b0, rgc_pkg::ADDR_LIMIT, 32'h0);
        chk(rd & 32'hFF, {24'h0, rgc_pkg::LIMIT_RST}, "lane 0 off write");
        $display("test reset done");
    endtask
    task automatic t_fixed();
        for (int c = 1; c <= 6; c++) begin
            wb(1'b1, rgc_pkg::ADDR_FRONT_AMP, 32'h80 | c);
            cyc(2);
            chk({29'h0, lna_gain_o}, c, "fixed gain");
            chk({31'h0, lna_impedance_sel_o}, 32'h1, "imp 200");
            wb(1'b0, rgc_pkg::ADDR_FRONT_AMP, 32'h0);
            chk((rd >> 3) & 32'h7, c, "gain now");
        end
        wb(1'b1, rgc_pkg::ADDR_FRONT_AMP, {29'h0, rgc_pkg::GAIN_AUTO});
        cyc(2);
        chk({31'h0, lna_impedance_sel_o}, 32'h0, "imp 50");
        $display("test fixed done");
    endtask
    task automatic t_auto();
        wb(1'b1, rgc_pkg::ADDR_LIMIT, 32'h40);
        wb(1'b1, rgc_pkg::ADDR_STEP_LIM_LO, 32'h80706050);
        wb(1'b1, rgc_pkg::ADDR_STEP_LIM_HI, 32'h90);
        wb(1'b1, rgc_pkg::ADDR_RX_CTRL, 32'h0003);
        cyc(3);
        chk({31'h0, in_wait_o}, 32'h1, "enter wait");
        rgc_front_model_i.sample(8'h75);
        rgc_front_model_i.sample(8'h30);
        rgc_front_model_i.sample(8'h75);
        cyc(2);
        chk({31'h0, in_wait_o}, 32'h1, "broken run");
        rgc_front_model_i.sample(8'h75);
        cyc(2);
        chk({31'h0, in_wait_o}, 32'h0, "leave wait");
        chk({29'h0, lna_gain_o}, 32'h4, "step pick");
        wb(1'b0, rgc_pkg::ADDR_FRONT_AMP, 32'h0);
        chk((rd >> 3) & 32'h7, 32'h4, "gain readable");
        wb(1'b0, rgc_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'hC, 32'h8, "status hold");
        fifo_empty_i <= 1'b1;
        cyc(100);
        chk({30'h0, in_wait_o, 1'b0} | lna_gain_o, 32'h4, "kept gain");
        wb(1'b1, rgc_pkg::ADDR_RX_CTRL, 32'h0207);
        n = 0;
        while (in_wait_o !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        // expect 2 units of 8 bits each; allow a few pipeline clocks
        chk(n >= 2 * 8 * BITC - 4 && n <= 2 * 8 * BITC + 4, 1, "rearm delay");
        @(posedge clk_i);
        fifo_empty_i <= 1'b0;
        rgc_front_model_i.sample(8'h95);
        rgc_front_model_i.sample(8'h95);
        cyc(2);
        chk({29'h0, lna_gain_o}, {29'h0, rgc_pkg::GAIN_G6}, "top step");
        wb(1'b1, rgc_pkg::ADDR_RX_CTRL, 32'h000B);
        cyc(3);
        chk({31'h0, in_wait_o}, 32'h1, "rearm cmd");
        wb(1'b0, rgc_pkg::ADDR_RX_CTRL, 32'h0);
        chk(rd & 32'h8, 32'h0, "cmd self clear");
        rgc_front_model_i.sample(8'h55);
        rgc_front_model_i.sample(8'h55);
        cyc(2);
        chk({29'h0, lna_gain_o}, 32'h2, "low step");
        $display("test auto done");
    endtask
    task automatic t_dgain();
        logic [7:0] g0;
        wb(1'b1, rgc_pkg::ADDR_DGAIN_CFG, {24'h0, rgc_pkg::DGAIN_OFF});
        rgc_front_model_i.set_amp(8'h40);
        cyc(1);
        g0 = digital_gain_o;
        // watch every cycle: the tick is a one-cycle pulse
        n = 0;
        repeat (4 * BITC) begin
            cyc(1);
            if (digital_gain_tick_o === 1'b1) n++;
        end
        chk(n, 0, "off no tick");
        chk({24'h0, digital_gain_o}, {24'h0, g0}, "off gain held");
        wb(1'b1, rgc_pkg::ADDR_DGAIN_CFG, {24'h0, rgc_pkg::DGAIN_LOWBETA});
        n = 0;
        while (digital_gain_tick_o !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        g0 = digital_gain_o;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (digital_gain_tick_o !== 1'b1 && n < 100);
        chk(n, 2 * BITC, "tick period");
        cyc(1);
        chk(digital_gain_o > g0, 1, "gain rises while lna frozen");
        wb(1'b1, rgc_pkg::ADDR_RX_CTRL, 32'h0001);
        rgc_front_model_i.set_amp(8'hC0);
        cyc(4 * BITC);
        g0 = digital_gain_o;
        cyc(4 * BITC);
        chk(digital_gain_o < g0, 1, "continuous mode down");
        $display("test dgain done");
    endtask
    task automatic t_bw();
        wb(1'b1, rgc_pkg::ADDR_BW, 32'h3A12);
        wb(1'b1, rgc_pkg::ADDR_RX_CTRL, 32'h0019);
        afc_busy_i <= 1'b1;
        cyc(4);
        chk({24'h0, bandwidth_o}, 32'h3A, "afc bw");
        @(posedge clk_i);
        afc_busy_i <= 1'b0;
        cyc(4);
        // still acquiring: the afc bandwidth stays in use
        chk({24'h0, bandwidth_o}, 32'h3A, "afc bw in wait");
        rgc_front_model_i.sample(8'h55);
        rgc_front_model_i.sample(8'h55);
        cyc(4);
        chk({24'h0, bandwidth_o}, 32'h12, "normal bw");
        chk({{22{ref_level_o[9]}}, ref_level_o}, 32'hFFFFFF78, "ref level");
        @(posedge clk_i);
        afc_busy_i <= 1'b1;
        cyc(4);
        chk({24'h0, bandwidth_o}, 32'h3A, "afc busy bw");
        chk({{22{ref_level_o[9]}}, ref_level_o}, 32'hFFFFFFA0, "afc ref level");
        $display("test bw done");
    endtask
    initial begin
        rst_i <= 1'b1;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_adr_i <= 8'h00;
        wb_dat_i <= 32'h0;
        wb_sel_i <= 4'h0;
        wb_lanes = 4'hF;
        fifo_empty_i <= 1'b0;
        afc_busy_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_fixed();
        t_auto();
        t_dgain();
        t_bw();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end
endmodule
`default_nettype wire
